// ===== serial_bcd_calendar_clock.sv
// Function
// - Slave only; start then fixed address.
// - Eight locations: time bytes then calibration.
// - Pointer advances after every data byte.
// - Time held in BCD, 24-hour.
// - Month lengths and leap February handled.
// - Counters seconds through century.
// - Timebase from 32.768 kHz oscillator.
// - Power fail aborts access, resets pointer.
// - Link ignored during power fail.
// - Link accepted again after power returns.
// - Word address after write-direction address byte.
// - User copy frozen during access with pointer on clock.
// - Divider chain reset after clock write.
// - Century toggle enable; halt bit stops oscillator.
`timescale 1ns/1ps
`include "rtc_params.svh"

module serial_bcd_calendar_clock
#(
	parameter int TICKS_PER_SEC = `OSC_FREQ_HZ
)
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst_b,
	// Crystal oscillator.
	input wire logic osc_32k,
	// Supply monitor.
	input wire logic power_fail,
	// Two-wire link.
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);
	import rtc_pkg::*;

	link_regs_type s_ff;
	link_regs_type nxt_s;
	clock_bytes_type time_bytes;
	logic osc_tick;
	logic core_load;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	function automatic logic [2:0] ptr_inc(input logic [2:0] p);
		return (p == `LOC_CAL) ? `LOC_SEC : p + 3'h1;
	endfunction

	// ----------------------------------------------------------------
	// Link and user copy
	// ----------------------------------------------------------------

	logic scl_rise, scl_fall, start_c, stop_c;

	always_comb
	begin
		nxt_s = s_ff;
		// Only the later stages of each synchroniser feed logic, never the first.
		nxt_s.scl_s1 = scl_in;
		nxt_s.scl_s2 = s_ff.scl_s1;
		nxt_s.scl_d = s_ff.scl_s2;
		nxt_s.sda_s1 = sda_in;
		nxt_s.sda_s2 = s_ff.sda_s1;
		nxt_s.sda_d = s_ff.sda_s2;
		nxt_s.pf_s1 = power_fail;
		nxt_s.pf_s2 = s_ff.pf_s1;
		nxt_s.osc_s1 = osc_32k;
		nxt_s.osc_s2 = s_ff.osc_s1;
		nxt_s.osc_d = s_ff.osc_s2;
		scl_rise = s_ff.scl_s2 && !s_ff.scl_d;
		scl_fall = !s_ff.scl_s2 && s_ff.scl_d;
		start_c = s_ff.scl_s2 && s_ff.scl_d && s_ff.sda_d && !s_ff.sda_s2;
		stop_c = s_ff.scl_s2 && s_ff.scl_d && !s_ff.sda_d && s_ff.sda_s2;
		core_load = 1'b0;

		// The user copy follows the running time unless a clock location is
		// being accessed or a written time has not yet reached the core.
		if (!(s_ff.busy && s_ff.ptr != `LOC_CAL) && !s_ff.dirty)
			nxt_s.user[6:0] = time_bytes;

		if (s_ff.pf_s2)
		begin
			// A pending write is discarded rather than half applied.
			nxt_s.state = LINK_IDLE;
			nxt_s.ptr = `PTR_RESET;
			nxt_s.sda_oe = 1'b0;
			nxt_s.busy = 1'b0;
			nxt_s.dirty = 1'b0;
		end
		else if (start_c || stop_c)
		begin
			core_load = s_ff.dirty;
			nxt_s.dirty = 1'b0;
			nxt_s.busy = 1'b0;
			nxt_s.sda_oe = 1'b0;
			nxt_s.cnt = '0;
			nxt_s.state = start_c ? LINK_ADDR : LINK_IDLE;
		end
		else
		begin
			unique case (s_ff.state)
				LINK_IDLE, LINK_SKIP:
				begin
					nxt_s.sda_oe = 1'b0;
				end
				LINK_ADDR:
				begin
					if (scl_rise)
					begin
						nxt_s.shift = {s_ff.shift[6:0], s_ff.sda_s2};
						nxt_s.cnt = s_ff.cnt + 4'h1;
					end
					else if (scl_fall && s_ff.cnt == `BITS_PER_BYTE)
					begin
						if (s_ff.shift[7:1] == `SLAVE_ADDR7)
						begin
							nxt_s.state = LINK_ADDR_ACK;
							nxt_s.sda_oe = 1'b1;
							nxt_s.rw = s_ff.shift[0];
							nxt_s.first = !s_ff.shift[0];
							nxt_s.busy = 1'b1;
						end
						else
							nxt_s.state = LINK_SKIP;
					end
				end
				LINK_ADDR_ACK:
				begin
					if (scl_fall)
					begin
						nxt_s.cnt = '0;
						if (s_ff.rw)
						begin
							nxt_s.state = LINK_TX;
							nxt_s.tx = {s_ff.user[s_ff.ptr][6:0], 1'b0};
							nxt_s.sda_oe = !s_ff.user[s_ff.ptr][7];
							nxt_s.cnt = `BIT_FIRST;
						end
						else
						begin
							nxt_s.state = LINK_RX;
							nxt_s.sda_oe = 1'b0;
						end
					end
				end
				LINK_RX:
				begin
					if (scl_rise)
					begin
						nxt_s.shift = {s_ff.shift[6:0], s_ff.sda_s2};
						nxt_s.cnt = s_ff.cnt + 4'h1;
					end
					else if (scl_fall && s_ff.cnt == `BITS_PER_BYTE)
					begin
						nxt_s.state = LINK_RX_ACK;
						nxt_s.sda_oe = 1'b1;
						if (s_ff.first)
						begin
							nxt_s.ptr = s_ff.shift[2:0];
							nxt_s.first = 1'b0;
						end
						else
						begin
							nxt_s.user[s_ff.ptr] = s_ff.shift;
							if (s_ff.ptr != `LOC_CAL)
								nxt_s.dirty = 1'b1;
							nxt_s.ptr = ptr_inc(s_ff.ptr);
						end
					end
				end
				LINK_RX_ACK:
				begin
					if (scl_fall)
					begin
						nxt_s.state = LINK_RX;
						nxt_s.sda_oe = 1'b0;
						nxt_s.cnt = '0;
					end
				end
				LINK_TX:
				begin
					if (scl_fall)
					begin
						if (s_ff.cnt == `BITS_PER_BYTE)
						begin
							nxt_s.state = LINK_TX_ACK;
							nxt_s.sda_oe = 1'b0;
						end
						else
						begin
							nxt_s.sda_oe = !s_ff.tx[7];
							nxt_s.tx = {s_ff.tx[6:0], 1'b0};
							nxt_s.cnt = s_ff.cnt + 4'h1;
						end
					end
				end
				LINK_TX_ACK:
				begin
					if (scl_rise)
					begin
						nxt_s.acked = !s_ff.sda_s2;
						nxt_s.ptr = ptr_inc(s_ff.ptr);
					end
					else if (scl_fall)
					begin
						if (s_ff.acked)
						begin
							nxt_s.state = LINK_TX;
							nxt_s.tx = {s_ff.user[s_ff.ptr][6:0], 1'b0};
							nxt_s.sda_oe = !s_ff.user[s_ff.ptr][7];
							nxt_s.cnt = `BIT_FIRST;
						end
						else
							nxt_s.state = LINK_SKIP;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_ff <= '0;
			s_ff.scl_s1 <= 1'b1;
			s_ff.scl_s2 <= 1'b1;
			s_ff.scl_d <= 1'b1;
			s_ff.sda_s1 <= 1'b1;
			s_ff.sda_s2 <= 1'b1;
			s_ff.sda_d <= 1'b1;
		end
		else
			s_ff <= nxt_s;
	end

	// ----------------------------------------------------------------
	// Timekeeping core
	// ----------------------------------------------------------------

	assign osc_tick = s_ff.osc_s2 && !s_ff.osc_d;

	calendar_core
	#(
		.TICKS_PER_SEC(TICKS_PER_SEC)
	)
	u_core
	(
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.osc_tick(osc_tick),
		.load(core_load),
		.load_bytes(s_ff.user[6:0]),
		.time_bytes(time_bytes)
	);

	// Open drain: the line is only ever pulled low.
	assign sda_out = 1'b0;
	assign sda_oe = s_ff.sda_oe;

endmodule // serial_bcd_calendar_clock

// ===== rtc_params.svh
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// Link addressing.
`define SLAVE_ADDR7 7'h68
`define LOC_SEC 3'h0
`define LOC_CAL 3'h7
`define PTR_RESET 3'h0
`define BITS_PER_BYTE 4'h8
`define BIT_FIRST 4'h1

// Field positions.
`define HALT_BIT 7
`define CEB_BIT 7
`define CB_BIT 6

// BCD limits.
`define BCD_ZERO 8'h00
`define BCD_ONE 8'h01
`define BCD_NINE 4'h9
`define SEC_LAST 8'h59
`define HOUR_LAST 8'h23
`define DAY_LAST 8'h07
`define MON_LAST 8'h12
`define YEAR_LAST 8'h99
`define DATE_28 8'h28
`define DATE_29 8'h29
`define DATE_30 8'h30
`define DATE_31 8'h31
`define MON_FEB 8'h02
`define MON_APR 8'h04
`define MON_JUN 8'h06
`define MON_SEP 8'h09
`define MON_NOV 8'h11

// Field masks.
`define MASK_SEC 8'h7f
`define MASK_HOUR 8'h3f
`define MASK_DAY 8'h07
`define MASK_DATE 8'h3f
`define MASK_MON 8'h1f

// Timebase in Hz.
`define OSC_FREQ_HZ 32768

`endif

// ===== rtc_pkg.sv
package rtc_pkg;

	typedef logic [6:0][7:0] clock_bytes_type;
	typedef logic [7:0][7:0] all_bytes_type;

	typedef enum logic [2:0]
	{
		LINK_IDLE = 3'b000,
		LINK_ADDR = 3'b001,
		LINK_ADDR_ACK = 3'b011,
		LINK_RX = 3'b010,
		LINK_RX_ACK = 3'b110,
		LINK_TX = 3'b111,
		LINK_TX_ACK = 3'b101,
		LINK_SKIP = 3'b100
	} link_state_type;

	typedef struct packed
	{
		clock_bytes_type time_bytes;
		logic [15:0] div;
	} core_state_type;

	typedef struct packed
	{
		logic scl_s1;
		logic scl_s2;
		logic scl_d;
		logic sda_s1;
		logic sda_s2;
		logic sda_d;
		logic pf_s1;
		logic pf_s2;
		logic osc_s1;
		logic osc_s2;
		logic osc_d;
		link_state_type state;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic [7:0] tx;
		logic [2:0] ptr;
		logic rw;
		logic first;
		logic busy;
		logic dirty;
		logic acked;
		logic sda_oe;
		all_bytes_type user;
	} link_regs_type;

endpackage

// ===== calendar_core.sv
`timescale 1ns/1ps
`include "rtc_params.svh"

module calendar_core
#(
	parameter int TICKS_PER_SEC = `OSC_FREQ_HZ
)
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst_b,
	// Timebase.
	input wire logic osc_tick,
	// Load from the user copy.
	input wire logic load,
	input wire rtc_pkg::clock_bytes_type load_bytes,
	// Running time.
	output rtc_pkg::clock_bytes_type time_bytes
);
	import rtc_pkg::*;

	localparam logic [15:0] DIV_LAST = 16'(TICKS_PER_SEC - 1);

	core_state_type s_ff;
	core_state_type nxt_s;

	function automatic logic [7:0] bcd_next(input logic [7:0] v, input logic [7:0] last, input logic [7:0] first);
		if (v == last)
			return first;
		else if (v[3:0] == `BCD_NINE)
			return {v[7:4] + 4'h1, 4'h0};
		else
			return v + `BCD_ONE;
	endfunction

	function automatic logic is_leap(input logic [7:0] yr);
		if (yr[4])
			return (yr[3:0] == 4'h2) || (yr[3:0] == 4'h6);
		else
			return (yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) || (yr[3:0] == 4'h8);
	endfunction

	function automatic logic [7:0] month_last(input logic [7:0] mon, input logic [7:0] yr);
		unique case (mon)
			`MON_FEB: return is_leap(yr) ? `DATE_29 : `DATE_28;
			`MON_APR, `MON_JUN, `MON_SEP, `MON_NOV: return `DATE_30;
			default: return `DATE_31;
		endcase
	endfunction

	logic [7:0] sec, min, hr, day, date, mon, yr;

	always_comb
	begin
		nxt_s = s_ff;
		sec = s_ff.time_bytes[0] & `MASK_SEC;
		min = s_ff.time_bytes[1];
		hr = s_ff.time_bytes[2] & `MASK_HOUR;
		day = s_ff.time_bytes[3] & `MASK_DAY;
		date = s_ff.time_bytes[4] & `MASK_DATE;
		mon = s_ff.time_bytes[5] & `MASK_MON;
		yr = s_ff.time_bytes[6];
		if (load)
		begin
			// A finished write restarts the second from zero.
			nxt_s.time_bytes = load_bytes;
			nxt_s.div = '0;
		end
		else if (osc_tick && !s_ff.time_bytes[0][`HALT_BIT])
		begin
			if (s_ff.div != DIV_LAST)
				nxt_s.div = s_ff.div + 16'h0001;
			else
			begin
				nxt_s.div = '0;
				// Seconds through century in BCD, 24-hour.
				nxt_s.time_bytes[0] = {s_ff.time_bytes[0][`HALT_BIT], 7'(bcd_next(sec, `SEC_LAST, `BCD_ZERO))};
				if (sec == `SEC_LAST)
				begin
					nxt_s.time_bytes[1] = bcd_next(min, `SEC_LAST, `BCD_ZERO);
					if (min == `SEC_LAST)
					begin
						nxt_s.time_bytes[2][5:0] = 6'(bcd_next(hr, `HOUR_LAST, `BCD_ZERO));
						if (hr == `HOUR_LAST)
						begin
							nxt_s.time_bytes[3] = bcd_next(day, `DAY_LAST, `BCD_ONE);
							nxt_s.time_bytes[4] = bcd_next(date, month_last(mon, yr), `BCD_ONE);
							if (date == month_last(mon, yr))
							begin
								nxt_s.time_bytes[5] = bcd_next(mon, `MON_LAST, `BCD_ONE);
								if (mon == `MON_LAST)
								begin
									nxt_s.time_bytes[6] = bcd_next(yr, `YEAR_LAST, `BCD_ZERO);
									if (yr == `YEAR_LAST && s_ff.time_bytes[2][`CEB_BIT])
										nxt_s.time_bytes[2][`CB_BIT] = !s_ff.time_bytes[2][`CB_BIT];
								end
							end
						end
					end
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign time_bytes = s_ff.time_bytes;

endmodule // calendar_core

// ===== serial_bcd_calendar_clock_assertions.sv
`timescale 1ns/1ps
module serial_bcd_calendar_clock_checker
#(
	parameter int TICKS_PER_SEC = 32768
)
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst_b,
	// Pins.
	input wire logic osc_32k,
	input wire logic power_fail,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe
);
	// ----
	// Bit counter.
	// ----
	// Raw pins run a few cycles ahead of the design's synchronised view.
	logic scl_ff;
	logic sda_ff;
	logic [3:0] bits_ff;
	logic [7:0] addr_ff;
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			scl_ff <= 1'b1;
			sda_ff <= 1'b1;
			bits_ff <= 4'hf;
			addr_ff <= 8'h00;
		end
		else
		begin
			scl_ff <= scl_in;
			sda_ff <= sda_in;
			if (scl_in && scl_ff && sda_ff && !sda_in)
				bits_ff <= 4'h0;
			else if (scl_in && !scl_ff && bits_ff != 4'hf)
				bits_ff <= bits_ff + 4'h1;
			if (scl_in && !scl_ff && bits_ff < 4'h8)
				addr_ff <= {addr_ff[6:0], sda_in};
		end
	end
	// ----
	// Properties.
	// ----
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence s_own;
		$fell(scl_in) && bits_ff == 4'h8 && addr_ff[7:1] == 7'h68 && !power_fail;
	endsequence
	sequence s_pf;
		power_fail[*5];
	endsequence
	AST_SDA_OUT: assert property (!sda_out) else $error("sda_out high");
	AST_ADDR_QUIET: assert property (bits_ff < 4'h8 |-> !sda_oe) else $error("drive in address");
	AST_OWN_ACK: assert property (s_own |-> ##[2:6] sda_oe) else $error("no address ack");
	AST_FOREIGN: assert property (bits_ff > 4'h7 && addr_ff[7:1] != 7'h68 |-> !sda_oe) else $error("foreign");
	AST_RISE_LOW: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in)) else $error("late drive");
	AST_OE_HOLD: assert property ($rose(sda_oe) |-> sda_oe[*8]) else $error("short drive");
	AST_OE_STABLE: assert property ((scl_in && !power_fail)[*5] |-> $stable(sda_oe)) else $error("drive moved");
	AST_PF_QUIET: assert property (s_pf |-> !sda_oe) else $error("drive in power fail");
endmodule // serial_bcd_calendar_clock_checker
bind serial_bcd_calendar_clock serial_bcd_calendar_clock_checker #(.TICKS_PER_SEC(TICKS_PER_SEC)) chk
(
	.sys_clk(sys_clk), .rst_b(rst_b), .osc_32k(osc_32k), .power_fail(power_fail),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe)
);

// ===== i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model
(
	// Clock.
	input wire logic sys_clk,
	// Bus.
	input wire logic sda_line,
	output logic scl,
	output logic sda
);
	// ----
	// Bus master.
	// ----
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// Start when a is 1, stop when 0; the slave has let go before the clock rises.
	task automatic cond(input logic a);
		wt(2);
		sda = a;
		wt(5);
		scl = 1'b1;
		wt(4);
		sda = !a;
		wt(4);
		scl = !a;
	endtask
	// Six low cycles leave room for the slave's reply delay.
	task automatic clk_bit(input logic b, output logic r);
		wt(1);
		sda = b;
		wt(5);
		scl = 1'b1;
		wt(4);
		r = sda_line;
		scl = 1'b0;
	endtask
	// Address byte carries the direction bit last.
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i], r);
		clk_bit(1'b1, r);
		ack = !r;
	endtask
	task automatic rd_byte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			clk_bit(1'b1, d[i]);
		clk_bit(!ack, r);
	endtask
endmodule // i2c_host_model

// ===== tb_serial_bcd_calendar_clock.sv
`timescale 1ns/1ps
module tb_serial_bcd_calendar_clock;
	// ----
	// Harness.
	// ----
	// Four rising osc edges a second keep each rollover short.
	localparam int TICKS = 4;
	logic sys_clk;
	logic rst_b;
	logic osc_32k;
	logic power_fail;
	logic scl, sda, sda_out, sda_oe, sda_line;
	int err_total = 0;
	int check_count = 0;
	int cycles = 0;
	assign sda_line = sda & ~(sda_oe & ~sda_out);
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial
	begin
		osc_32k = 1'b0;
		forever #15258.789 osc_32k = ~osc_32k;
	end
	serial_bcd_calendar_clock #(.TICKS_PER_SEC(TICKS)) uut
	(
		.sys_clk(sys_clk), .rst_b(rst_b), .osc_32k(osc_32k), .power_fail(power_fail),
		.scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe)
	);
	i2c_host_model host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda(sda));
	task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cmp1(input string n, input logic e, input logic g);
		cmp8(n, {7'h00, e}, {7'h00, g});
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 50000)
		begin
			err_total++;
			end_sim();
		end
	end
	// ----
	// Transfers.
	// ----
	task automatic put(input logic [2:0] p, input logic [7:0] v[$]);
		logic a;
		host.cond(1'b1);
		host.wr_byte(8'hd0, a);
		cmp1("addr ack", 1'b1, a);
		host.wr_byte({5'h00, p}, a);
		foreach (v[i])
		begin
			host.wr_byte(v[i], a);
			cmp1("data ack", 1'b1, a);
		end
		host.cond(1'b0);
	endtask
	task automatic get(input logic setp, input logic [2:0] p, input logic [7:0] e[$]);
		logic a;
		logic [7:0] d;
		if (setp)
		begin
			host.cond(1'b1);
			host.wr_byte(8'hd0, a);
			host.wr_byte({5'h00, p}, a);
		end
		host.cond(1'b1);
		host.wr_byte(8'hd1, a);
		cmp1("read ack", 1'b1, a);
		foreach (e[i])
		begin
			host.rd_byte(i != e.size() - 1, d);
			cmp8("byte", e[i], d);
		end
		host.cond(1'b0);
	endtask
	// ----
	// Scenarios.
	// ----
	// The wait passes one second after the divider restarts but not two.
	task automatic t_roll(input logic [7:0] h, dt, mo, yr, eh, ed, em, ey);
		put(3'h0, '{8'h59, 8'h59, h, 8'h07, dt, mo, yr});
		repeat (1500) @(negedge sys_clk);
		get(1'b1, 3'h2, '{eh, 8'h01, ed, em, ey});
		$display("rollover done");
	endtask
	task automatic t_halt();
		put(3'h0, '{8'h80, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h99, 8'h15});
		repeat (1500) @(negedge sys_clk);
		get(1'b1, 3'h0, '{8'h80, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h99, 8'h15, 8'h80});
		$display("halt done");
	endtask
	task automatic t_foreign();
		logic a;
		host.cond(1'b1);
		host.wr_byte(8'ha0, a);
		cmp1("foreign ack", 1'b0, a);
		host.wr_byte(8'h00, a);
		cmp1("foreign data", 1'b0, a);
		host.cond(1'b0);
		$display("foreign done");
	endtask
	task automatic t_pfail();
		logic a;
		host.cond(1'b1);
		host.wr_byte(8'hd0, a);
		host.wr_byte(8'h03, a);
		power_fail = 1'b1;
		host.wr_byte(8'h01, a);
		cmp1("fail ack", 1'b0, a);
		power_fail = 1'b0;
		host.cond(1'b0);
		get(1'b0, 3'h0, '{8'h80, 8'h59, 8'h23, 8'h07});
		$display("power fail done");
	endtask
	initial
	begin
		rst_b = 1'b0;
		power_fail = 1'b0;
		repeat (8) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (4) @(negedge sys_clk);
		get(1'b1, 3'h0, '{8'h00, 8'h00});
		$display("reset read done");
		t_roll(8'h23, 8'h28, 8'h02, 8'h23, 8'h00, 8'h01, 8'h03, 8'h23);
		t_roll(8'h23, 8'h28, 8'h02, 8'h24, 8'h00, 8'h29, 8'h02, 8'h24);
		t_roll(8'h23, 8'h30, 8'h04, 8'h24, 8'h00, 8'h01, 8'h05, 8'h24);
		t_roll(8'ha3, 8'h31, 8'h12, 8'h99, 8'hc0, 8'h01, 8'h01, 8'h00);
		t_halt();
		t_foreign();
		t_pfail();
		end_sim();
	end
endmodule // tb_serial_bcd_calendar_clock
